// file: core/secc_pkg.sv
package secc_pkg;
   // ----------------------------------------
   // Register indices and byte addresses
   // ----------------------------------------
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_CODE_CFG = 16'hA00D;
   localparam logic [15:0] IDX_CODE_FAL = 16'hA00E;
   localparam logic [15:0] IDX_CODE_FAH = 16'hA00F;
   localparam logic [15:0] IDX_CODE_ACT = 16'hA03E;
   localparam logic [15:0] IDX_SRAM_CFG = 16'hA02D;
   localparam logic [15:0] IDX_SRAM_FAL = 16'hA02E;
   localparam logic [15:0] IDX_SRAM_FAH = 16'hA02F;
   // Byte address is four times the index
   localparam logic [17:0] A_CODE_CFG = {IDX_CODE_CFG, 2'b00};
   localparam logic [17:0] A_CODE_FAL = {IDX_CODE_FAL, 2'b00};
   localparam logic [17:0] A_CODE_FAH = {IDX_CODE_FAH, 2'b00};
   localparam logic [17:0] A_CODE_ACT = {IDX_CODE_ACT, 2'b00};
   localparam logic [17:0] A_SRAM_CFG = {IDX_SRAM_CFG, 2'b00};
   localparam logic [17:0] A_SRAM_FAL = {IDX_SRAM_FAL, 2'b00};
   localparam logic [17:0] A_SRAM_FAH = {IDX_SRAM_FAH, 2'b00};
   // ----------------------------------------
   // Field positions of both config registers and the action register
   // ----------------------------------------
   localparam int B_EN = 7;
   localparam int B_UIE = 5;
   localparam int B_CIE = 4;
   localparam int B_UF = 1;
   localparam int B_CF = 0;
   localparam int B_RSTMODE = 0;
   // ----------------------------------------
   // Reset values and array shape
   // ----------------------------------------
   localparam logic [7:0] CFG_RST = 8'h80;
   localparam logic [15:0] FA_RST = 16'h8000;
   localparam logic [7:0] ACT_RST = 8'h00;
   localparam int SRAM_WORDS = 2048;
   localparam int SRAM_WIDTH = 13;
endpackage

// file: core/secc_top.sv
`timescale 1ns/1ps
module secc_top
   import secc_pkg::*;
#(
   parameter int DEPTH = SRAM_WORDS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB register port
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [secc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU data port to the SRAM
   input wire logic dmem_req,
   input wire logic dmem_we,
   input wire logic [$clog2(DEPTH)-1:0] dmem_addr,
   input wire logic [7:0] dmem_wdata,
   output logic [7:0] dmem_rdata,
   output logic dmem_rvalid,
   // Program fetch with raw flash word
   input wire logic fetch_req,
   input wire logic [15:0] fetch_addr,
   input wire logic [15:0] fetch_word,
   output logic [7:0] fetch_data,
   output logic fetch_valid,
   // Flash controller read
   input wire logic fc_req,
   input wire logic [15:0] fc_word,
   output logic [15:0] fc_data,
   output logic fc_valid,
   // Event outputs
   output logic sram_irq,
   output logic code_irq,
   output logic soft_reset
);
   import secc_pkg::*;

   localparam int AW = $clog2(DEPTH);

   // Fault address is 16 bits wide, so the array cannot be deeper
   if (DEPTH < 2 || DEPTH > 65536) begin : g_depth_check
      $error("secc_top: DEPTH out of range");
   end

   // ----------------------------------------
   // Check-code functions
   // ----------------------------------------
   // Four Hamming bits plus overall parity over a byte
   function automatic logic [4:0] enc_byte(input logic [7:0] d);
      logic [3:0] p;
      p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      p[3] = ^d[7:4];
      return {^{d, p}, p};
   endfunction

   // Returns {uncorrectable, corrected, byte}
   function automatic logic [9:0] dec_byte(input logic [12:0] w);
      logic [4:0] c;
      logic [3:0] s;
      logic [7:0] fix;
      logic u;
      logic k;
      c = enc_byte(w[7:0]);
      s = c[3:0] ^ w[11:8];
      fix = 8'h00;
      u = 1'b0;
      k = 1'b0;
      if (^w) begin
         k = 1'b1;
         case (s)
            4'h3: fix[0] = 1'b1;
            4'h5: fix[1] = 1'b1;
            4'h6: fix[2] = 1'b1;
            4'h7: fix[3] = 1'b1;
            4'h9: fix[4] = 1'b1;
            4'hA: fix[5] = 1'b1;
            4'hB: fix[6] = 1'b1;
            4'hC: fix[7] = 1'b1;
            // No single flip gives these, so more bits are wrong
            4'hD, 4'hE, 4'hF: begin
               u = 1'b1;
               k = 1'b0;
            end
            default: ;
         endcase
      end else if (s != 4'h0) begin
         u = 1'b1;
      end
      return {u, k, w[7:0] ^ fix};
   endfunction

   // Returns {uncorrectable, corrected, nibble}; chk is {overall, p2, p1, p0}
   function automatic logic [5:0] dec_nib(input logic [3:0] d, input logic [3:0] chk);
      logic [2:0] p;
      logic [2:0] s;
      logic [3:0] fix;
      logic u;
      logic k;
      p[0] = d[0] ^ d[1] ^ d[3];
      p[1] = d[0] ^ d[2] ^ d[3];
      p[2] = d[1] ^ d[2] ^ d[3];
      s = p ^ chk[2:0];
      fix = 4'h0;
      u = 1'b0;
      k = 1'b0;
      if (^{d, chk}) begin
         k = 1'b1;
         case (s)
            3'h3: fix[0] = 1'b1;
            3'h5: fix[1] = 1'b1;
            3'h6: fix[2] = 1'b1;
            3'h7: fix[3] = 1'b1;
            default: ;
         endcase
      end else if (s != 3'h0) begin
         u = 1'b1;
      end
      return {u, k, d ^ fix};
   endfunction

   // Whole flash word to {uncorrectable, corrected, byte}
   function automatic logic [9:0] dec_flash(input logic [15:0] w);
      logic [5:0] lo;
      logic [5:0] hi;
      lo = dec_nib(w[3:0], w[11:8]);
      hi = dec_nib(w[7:4], w[15:12]);
      return {lo[5] | hi[5], (lo[4] | hi[4]) & ~(lo[5] | hi[5]), hi[3:0], lo[3:0]};
   endfunction

   // APB exact byte address match over all 18 bits, shared by read and write decode
   function automatic logic hit(input logic [17:0] a, input logic [17:0] reg_a);
      return a == reg_a;
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic s_en;
      logic s_uie;
      logic s_cie;
      logic s_uf;
      logic s_cf;
      logic [15:0] s_fa;
      logic c_sel;
      logic c_uie;
      logic c_cie;
      logic c_uf;
      logic c_cf;
      logic c_rst_mode;
      logic [15:0] c_fa;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] drdata;
      logic dvalid;
      logic [7:0] fdata;
      logic fvalid;
      logic [15:0] fcdata;
      logic fcvalid;
      logic sirq;
      logic cirq;
      logic srst;
   } secc_state_s;

   secc_state_s st_reg;
   secc_state_s st_next;
   logic [SRAM_WIDTH-1:0] mem [DEPTH];
   logic [9:0] d_dec;
   logic [9:0] f_dec;
   logic [9:0] fc_dec;
   logic d_rd;
   logic d_unc;
   logic d_cor;
   logic f_unc;
   logic f_cor;
   logic wr_acc;
   logic setup;
   logic [7:0] rbyte;
   logic mapped;

   // ----------------------------------------
   // Error detection on the data and fetch ports; flash controller reads are only decoded
   // ----------------------------------------
   // Read of the array is combinational so the checked byte is ready next edge
   assign d_dec = dec_byte(mem[dmem_addr]);
   assign d_rd = dmem_req & ~dmem_we;
   // Check bits mean nothing while protection is off
   assign d_unc = d_rd & st_reg.s_en & d_dec[9];
   assign d_cor = d_rd & st_reg.s_en & d_dec[8];
   assign f_dec = dec_flash(fetch_word);
   assign f_unc = fetch_req & f_dec[9];
   assign f_cor = fetch_req & f_dec[8];
   assign fc_dec = dec_flash(fc_word);
   assign wr_acc = psel & penable & pwrite;
   assign setup = psel & ~penable;

   // Read mux, sampled in the setup cycle
   always_comb begin
      rbyte = 8'h00;
      mapped = 1'b1;
      if (hit(paddr, A_SRAM_CFG)) begin
         rbyte = {st_reg.s_en, 1'b0, st_reg.s_uie, st_reg.s_cie, 2'b00, st_reg.s_uf, st_reg.s_cf};
      end else if (hit(paddr, A_SRAM_FAL)) begin
         rbyte = st_reg.s_fa[7:0];
      end else if (hit(paddr, A_SRAM_FAH)) begin
         rbyte = st_reg.s_fa[15:8];
      end else if (hit(paddr, A_CODE_CFG)) begin
         rbyte = {st_reg.c_sel, 1'b0, st_reg.c_uie, st_reg.c_cie, 2'b00, st_reg.c_uf, st_reg.c_cf};
      end else if (hit(paddr, A_CODE_FAL)) begin
         rbyte = st_reg.c_fa[7:0];
      end else if (hit(paddr, A_CODE_FAH)) begin
         rbyte = {2'b00, st_reg.c_fa[13:8]};
      end else if (hit(paddr, A_CODE_ACT)) begin
         rbyte = {7'h00, st_reg.c_rst_mode};
      end else begin
         mapped = 1'b0;
      end
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      // Zero-wait slave: data and error are prepared during setup
      st_next.pready = 1'b1;
      if (setup) begin
         st_next.prdata = {24'h000000, rbyte};
         st_next.pslverr = ~mapped;
      end
      // Config writes; a flag is only cleared by writing zero
      if (wr_acc && hit(paddr, A_SRAM_CFG)) begin
         st_next.s_en = pwdata[B_EN];
         st_next.s_uie = pwdata[B_UIE];
         st_next.s_cie = pwdata[B_CIE];
         st_next.s_uf = st_reg.s_uf & pwdata[B_UF];
         st_next.s_cf = st_reg.s_cf & pwdata[B_CF];
      end
      if (wr_acc && hit(paddr, A_CODE_CFG)) begin
         st_next.c_sel = pwdata[B_EN];
         st_next.c_uie = pwdata[B_UIE];
         st_next.c_cie = pwdata[B_CIE];
         st_next.c_uf = st_reg.c_uf & pwdata[B_UF];
         st_next.c_cf = st_reg.c_cf & pwdata[B_CF];
      end
      if (wr_acc && hit(paddr, A_CODE_ACT)) begin
         st_next.c_rst_mode = pwdata[B_RSTMODE];
      end
      // Address is captured only when no flag was already pending
      if ((d_unc || d_cor) && !st_reg.s_uf && !st_reg.s_cf) begin
         st_next.s_fa = 16'(dmem_addr);
      end
      // Hardware sets after the software write, so the set wins
      if (d_unc) begin
         st_next.s_uf = 1'b1;
      end
      if (d_cor) begin
         st_next.s_cf = 1'b1;
      end
      if (f_unc) begin
         st_next.c_uf = 1'b1;
      end
      if (f_cor) begin
         st_next.c_cf = 1'b1;
      end
      // Latest fetch error that interrupts or, in reset mode, resets overwrites the address
      if ((f_cor && st_reg.c_cie) || (f_unc && (st_reg.c_uie || st_reg.c_rst_mode))) begin
         st_next.c_fa = fetch_addr;
      end
      // SRAM read data; corrected byte when protection is on
      st_next.dvalid = d_rd;
      if (d_rd) begin
         st_next.drdata = st_reg.s_en ? d_dec[7:0] : mem[dmem_addr][7:0];
      end
      st_next.fvalid = fetch_req;
      if (fetch_req) begin
         st_next.fdata = f_dec[7:0];
      end
      st_next.fcvalid = fc_req;
      if (fc_req) begin
         st_next.fcdata = st_reg.c_sel ? {fc_word[15:8], fc_dec[7:0]} : fc_word;
      end
      // Reset mode replaces the uncorrectable interrupt
      st_next.srst = f_unc & st_reg.c_rst_mode;
      st_next.sirq = (st_next.s_uf & st_next.s_uie) | (st_next.s_cf & st_next.s_cie);
      st_next.cirq = (st_next.c_uf & st_next.c_uie & ~st_next.c_rst_mode)
                   | (st_next.c_cf & st_next.c_cie);
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         {st_reg.s_en, st_reg.s_uie, st_reg.s_cie, st_reg.s_uf, st_reg.s_cf} <= 5'(CFG_RST >> 3);
         st_reg.c_sel <= CFG_RST[B_EN];
         st_reg.c_rst_mode <= ACT_RST[B_RSTMODE];
         st_reg.s_fa <= FA_RST;
         st_reg.c_fa <= FA_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Array write; check bits stored as zero while protection is off
   always_ff @(posedge pclk) begin
      if (dmem_req && dmem_we) begin
         mem[dmem_addr] <= {st_reg.s_en ? enc_byte(dmem_wdata) : 5'h00, dmem_wdata};
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign dmem_rdata = st_reg.drdata;
   assign dmem_rvalid = st_reg.dvalid;
   assign fetch_data = st_reg.fdata;
   assign fetch_valid = st_reg.fvalid;
   assign fc_data = st_reg.fcdata;
   assign fc_valid = st_reg.fcvalid;
   assign sram_irq = st_reg.sirq;
   assign code_irq = st_reg.cirq;
   assign soft_reset = st_reg.srst;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_SRAM_READ_CLEAN: assert property (
      d_rd && st_reg.s_en && !d_dec[9] |=> dmem_rvalid && dmem_rdata == $past(d_dec[7:0]))
      else $error("SRAM read data not the checked byte");
   AST_SRAM_UNC_CAPTURE: assert property (
      d_unc && !st_reg.s_uf && !st_reg.s_cf |=> st_reg.s_uf && st_reg.s_fa == 16'($past(dmem_addr)))
      else $error("Uncorrectable SRAM error not captured");
   AST_SRAM_FA_FROZEN: assert property (
      (st_reg.s_uf || st_reg.s_cf) ##1 (st_reg.s_uf || st_reg.s_cf) |-> $stable(st_reg.s_fa))
      else $error("SRAM fault address moved while flag pending");
   AST_SRAM_EN_WRITE: assert property (
      wr_acc && hit(paddr, A_SRAM_CFG) |=> st_reg.s_en == $past(pwdata[B_EN]))
      else $error("SRAM enable not written");
   AST_CODE_UNC_FLAG: assert property (
      f_unc |=> (st_reg.c_uf && wr_acc) or (st_reg.c_uf ##1 st_reg.c_uf))
      else $error("Code uncorrectable flag not held");
   AST_CODE_COR_FLAG: assert property (
      f_cor |=> st_reg.c_cf && fetch_valid)
      else $error("Code correctable flag not set");
   AST_CODE_RESET: assert property (
      f_unc && st_reg.c_rst_mode |=> soft_reset ##1 (!soft_reset || $past(f_unc)))
      else $error("Software reset not pulsed");
   AST_FC_RAW: assert property (
      fc_req && !st_reg.c_sel |=> fc_valid && fc_data == $past(fc_word))
      else $error("Raw controller read altered");
   AST_SRAM_IRQ: assert property (
      sram_irq == ((st_reg.s_uf && st_reg.s_uie) || (st_reg.s_cf && st_reg.s_cie)))
      else $error("SRAM interrupt not flag and enable");

   COV_SRAM_COR: cover property (d_cor ##1 sram_irq);
   COV_SRAM_UNC: cover property (d_unc ##1 st_reg.s_uf);
   COV_CODE_COR: cover property (f_cor ##1 code_irq);
   COV_CODE_RST: cover property (f_unc ##1 soft_reset);
endmodule // secc_top

// file: test/secc_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// CPU side model: data bus, fetch bus, flash controller read
// ----------------------------------------
module secc_cpu_model (
   // Clock
   input wire logic pclk,
   // SRAM data bus
   output logic dmem_req,
   output logic dmem_we,
   output logic [10:0] dmem_addr,
   output logic [7:0] dmem_wdata,
   input wire logic [7:0] dmem_rdata,
   input wire logic dmem_rvalid,
   // Program fetch bus
   output logic fetch_req,
   output logic [15:0] fetch_addr,
   output logic [15:0] fetch_word,
   input wire logic [7:0] fetch_data,
   input wire logic fetch_valid,
   // Flash controller read
   output logic fc_req,
   output logic [15:0] fc_word,
   input wire logic [15:0] fc_data,
   input wire logic fc_valid
);
   // Buses start idle with defined levels
   initial begin
      dmem_req = 1'b0;
      dmem_we = 1'b0;
      dmem_addr = 11'h000;
      dmem_wdata = 8'h00;
      fetch_req = 1'b0;
      fetch_addr = 16'h0000;
      fetch_word = 16'h0000;
      fc_req = 1'b0;
      fc_word = 16'h0000;
   end
   // One SRAM access; released lines are inverted so a stale value is never trusted
   task automatic dm(input logic we, input logic [10:0] a, input logic [7:0] wd, output logic [7:0] rd,
                     output logic ok);
      @(posedge pclk);
      dmem_req <= 1'b1;
      dmem_we <= we;
      dmem_addr <= a;
      dmem_wdata <= wd;
      @(posedge pclk);
      dmem_req <= 1'b0;
      dmem_addr <= ~a;
      dmem_wdata <= ~wd;
      #1;
      rd = dmem_rdata;
      ok = (dmem_rvalid === !we);
   endtask
   // Software fills every location before trusting reads, after reset or a mode change
   task automatic init_all(input logic [7:0] v);
      logic [7:0] rd;
      logic ok;
      for (int i = 0; i < 2048; i++) begin
         dm(1'b1, i[10:0], v, rd, ok);
      end
   endtask
   // One instruction fetch with its raw flash word
   task automatic fetch(input logic [15:0] a, input logic [15:0] w, output logic [7:0] d, output logic ok);
      @(posedge pclk);
      fetch_req <= 1'b1;
      fetch_addr <= a;
      fetch_word <= w;
      @(posedge pclk);
      fetch_req <= 1'b0;
      fetch_addr <= ~a;
      fetch_word <= ~w;
      #1;
      d = fetch_data;
      ok = fetch_valid;
   endtask
   // One flash controller read
   task automatic fc(input logic [15:0] w, output logic [15:0] d, output logic ok);
      @(posedge pclk);
      fc_req <= 1'b1;
      fc_word <= w;
      @(posedge pclk);
      fc_req <= 1'b0;
      fc_word <= ~w;
      #1;
      d = fc_data;
      ok = fc_valid;
   endtask
endmodule // secc_cpu_model

// file: test/sram_and_code_ecc_checker_test.sv
`timescale 1ns/1ps
module sram_and_code_ecc_checker_test;
   import secc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sram_irq, code_irq, soft_reset;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic dmem_req, dmem_we, dmem_rvalid, fetch_req, fetch_valid, fc_req, fc_valid, err, ok;
   logic [10:0] dmem_addr, a;
   logic [7:0] dmem_wdata, dmem_rdata, fetch_data, d, g;
   logic [15:0] fetch_addr, fetch_word, fc_word, fc_data, m, fa, g16;
   integer seed = 32'h3423EB25;
   int n_mismatch = 0;
   int checks = 0;
   // ----------------------------------------
   // Clock, watchdog, instances
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Whole run needs about 5k cycles; a hang is cut well beyond that
   initial begin
      #400000;
      n_mismatch++;
      end_of_test();
   end
   secc_top #(.DEPTH(2048)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dmem_req(dmem_req), .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
      .dmem_rdata(dmem_rdata), .dmem_rvalid(dmem_rvalid), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .fetch_word(fetch_word), .fetch_data(fetch_data), .fetch_valid(fetch_valid), .fc_req(fc_req),
      .fc_word(fc_word), .fc_data(fc_data), .fc_valid(fc_valid), .sram_irq(sram_irq), .code_irq(code_irq),
      .soft_reset(soft_reset));
   secc_cpu_model cpu (.pclk(pclk), .dmem_req(dmem_req), .dmem_we(dmem_we), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .dmem_rvalid(dmem_rvalid), .fetch_req(fetch_req),
      .fetch_addr(fetch_addr), .fetch_word(fetch_word), .fetch_data(fetch_data), .fetch_valid(fetch_valid),
      .fc_req(fc_req), .fc_word(fc_word), .fc_data(fc_data), .fc_valid(fc_valid));
   // ----------------------------------------
   // Expectation functions and bench tasks
   // ----------------------------------------
   // Nibble check code, three Hamming bits plus overall even parity
   function automatic logic [3:0] nib(input logic [3:0] x);
      logic [2:0] c;
      c = {x[1] ^ x[2] ^ x[3], x[0] ^ x[2] ^ x[3], x[0] ^ x[1] ^ x[3]};
      nib = {^{x, c}, c};
   endfunction
   function automatic logic [15:0] cw(input logic [7:0] x);
      cw = {nib(x[7:4]), nib(x[3:0]), x};
   endfunction
   // One flipped bit inside the data or check part of the chosen nibble
   function automatic logic [15:0] flip(input logic hi, input logic [2:0] k);
      int p;
      p = (k < 4) ? k : k + 4;
      if (hi) p = p + 4;
      flip = 16'h0001 << p;
   endfunction
   task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] v);
      checks++;
      if (v !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, v);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic e, input logic v);
      checks++;
      if (v !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, v);
      end
   endtask
   // APB transfer; the wait for pready is bounded, never assumed
   task automatic apb(input logic wr, input logic [17:0] ad, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      if (n >= 16) cmp_bit("pready", 1'b1, pready);
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~ad;
      pwdata <= ~pwdata;
   endtask
   task automatic rreg(input logic [17:0] ad, input logic [7:0] e, input string nm);
      apb(1'b0, ad, 8'h00);
      cmp_val(nm, {8'h00, e}, rd[15:0]);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rreg(A_CODE_CFG, 8'h80, "code_cfg");
      rreg(A_SRAM_CFG, 8'h80, "sram_cfg");
      rreg(A_SRAM_FAL, 8'h00, "sram_fal");
      rreg(A_SRAM_FAH, 8'h80, "sram_fah");
      apb(1'b0, 18'h00100, 8'h00);
      cmp_bit("pslverr", 1'b1, err);
      apb(1'b1, A_SRAM_FAL, 8'hFF);
      rreg(A_SRAM_FAL, 8'h00, "sram_fal");
      cpu.init_all(8'h00);
      // Random write then read back with protection on
      repeat (32) begin
         a = 11'($random(seed));
         d = 8'($random(seed));
         cpu.dm(1'b1, a, d, g, ok);
         cpu.dm(1'b0, a, 8'h00, g, ok);
         cmp_val("dmem_rdata", {8'h00, d}, {8'h00, g});
         cmp_bit("dmem_rvalid", 1'b1, ok);
      end
      // Raw words stored with protection off: one set bit is correctable to zero, two are not
      apb(1'b1, A_SRAM_CFG, 8'h30);
      cpu.dm(1'b1, 11'h123, 8'h04, g, ok);
      cpu.dm(1'b1, 11'h456, 8'h18, g, ok);
      apb(1'b1, A_SRAM_CFG, 8'hB0);
      cpu.dm(1'b0, 11'h123, 8'h00, g, ok);
      cmp_val("dmem_rdata", 16'h0000, {8'h00, g});
      rreg(A_SRAM_CFG, 8'hB1, "sram_cfg");
      cmp_bit("sram_irq", 1'b1, sram_irq);
      rreg(A_SRAM_FAL, 8'h23, "sram_fal");
      rreg(A_SRAM_FAH, 8'h01, "sram_fah");
      cpu.dm(1'b0, 11'h456, 8'h00, g, ok);
      rreg(A_SRAM_CFG, 8'hB3, "sram_cfg");
      rreg(A_SRAM_FAL, 8'h23, "sram_fal");
      apb(1'b1, A_SRAM_CFG, 8'h82);
      rreg(A_SRAM_CFG, 8'h82, "sram_cfg");
      cmp_bit("sram_irq", 1'b0, sram_irq);
      apb(1'b1, A_SRAM_CFG, 8'hA2);
      rreg(A_SRAM_CFG, 8'hA2, "sram_cfg");
      cmp_bit("sram_irq", 1'b1, sram_irq);
      apb(1'b1, A_SRAM_CFG, 8'hA0);
      cpu.dm(1'b0, 11'h456, 8'h00, g, ok);
      rreg(A_SRAM_FAL, 8'h56, "sram_fal");
      rreg(A_SRAM_FAH, 8'h04, "sram_fah");
      apb(1'b1, A_SRAM_CFG, 8'hA0);
      cpu.dm(1'b1, 11'h123, 8'h5A, g, ok);
      cpu.dm(1'b0, 11'h123, 8'h00, g, ok);
      cmp_val("dmem_rdata", 16'h005A, {8'h00, g});
      rreg(A_SRAM_CFG, 8'hA0, "sram_cfg");
      // Fetches with at most one error per nibble are corrected
      apb(1'b1, A_CODE_CFG, 8'h30);
      repeat (24) begin
         d = 8'($random(seed));
         fa = 16'($random(seed));
         m = 16'h0000;
         if ($random(seed) & 1) m = m | flip(1'b0, 3'($random(seed)));
         if ($random(seed) & 1) m = m | flip(1'b1, 3'($random(seed)));
         cpu.fetch(fa, cw(d) ^ m, g, ok);
         cmp_val("fetch_data", {8'h00, d}, {8'h00, g});
         cmp_bit("fetch_valid", 1'b1, ok);
         rreg(A_CODE_CFG, {7'h18, m != 16'h0000}, "code_cfg");
         cmp_bit("code_irq", m != 16'h0000, code_irq);
         if (m != 16'h0000) begin
            rreg(A_CODE_FAL, fa[7:0], "code_fal");
            rreg(A_CODE_FAH, {2'b00, fa[13:8]}, "code_fah");
         end
         apb(1'b1, A_CODE_CFG, 8'h30);
         for (int s = 0; s < 2; s++) begin
            apb(1'b1, A_CODE_CFG, {s[0], 7'h00});
            cpu.fc(cw(d) ^ m, g16, ok);
            cmp_val("fc_data", s ? {cw(d) ^ m} & 16'hFF00 | {8'h00, d} : cw(d) ^ m, g16);
            cmp_bit("fc_valid", 1'b1, ok);
         end
         apb(1'b1, A_CODE_CFG, 8'h30);
      end
      // Uncorrectable fetch raises the interrupt
      apb(1'b1, A_CODE_CFG, 8'h20);
      cpu.fetch(16'h3ABC, cw(8'hC5) ^ flip(1'b0, 3'd0) ^ flip(1'b0, 3'd5), g, ok);
      rreg(A_CODE_CFG, 8'h22, "code_cfg");
      cmp_bit("code_irq", 1'b1, code_irq);
      rreg(A_CODE_FAL, 8'hBC, "code_fal");
      rreg(A_CODE_FAH, 8'h3A, "code_fah");
      // Flag is set although its interrupt is disabled
      apb(1'b1, A_CODE_CFG, 8'h00);
      cpu.fetch(16'h0100, cw(8'h3C) ^ flip(1'b1, 3'd6), g, ok);
      rreg(A_CODE_CFG, 8'h01, "code_cfg");
      cmp_bit("code_irq", 1'b0, code_irq);
      // Reset mode: uncorrectable fetch gives one reset pulse instead of an interrupt
      apb(1'b1, A_CODE_ACT, 8'h01);
      apb(1'b1, A_CODE_CFG, 8'h20);
      cpu.fetch(16'h0200, cw(8'h99) ^ flip(1'b1, 3'd1) ^ flip(1'b1, 3'd4), g, ok);
      cmp_bit("soft_reset", 1'b1, soft_reset);
      @(posedge pclk);
      #1;
      cmp_bit("soft_reset", 1'b0, soft_reset);
      rreg(A_CODE_CFG, 8'h22, "code_cfg");
      cmp_bit("code_irq", 1'b0, code_irq);
      end_of_test();
   end
   // Single place where the run ends
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
endmodule // sram_and_code_ecc_checker_test
